// *** rtl/mode_strap_and_power_gating.sv ***
`timescale 1ns/100ps

// Overview of operation
// - capture straps at reset release; port select skips mode and rate straps
// - sleep and direction pins act live
// - rx sleep stops adc, rx clocks, bias
// - tx sleep stops dac, tx clocks; pll runs
// - direction acts only in half duplex
// - direction low: tx clock off, bus out
// - direction high: rx clocks off, bus in
// - direction gates digital clocks only
// - economy strap selects adc low power
// - serial select strap picks port or straps
// - duplex strap: low half, high full
// - width strap: low wide, high narrow
// - rate straps set interpolation and pll
module mode_strap_and_power_gating (
  input  wire logic                                 mclk,
  input  wire logic                                 rst_b,
  // strap and control pins
  input  wire logic                                 serial_select_pin,
  input  wire logic                                 serial_output_pin,
  input  wire logic                                 serial_data_pin,
  input  wire logic                                 serial_clock_pin,
  input  wire logic                                 flex_pin_a,
  input  wire logic                                 flex_pin_b,
  input  wire logic                                 adc_economy_strap,
  input  wire logic                                 rx_sleep_pin,
  input  wire logic                                 tx_sleep_pin,
  // register port
  input  wire logic [mode_strap_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [mode_strap_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                                 reg_wr,
  input  wire logic                                 reg_rd,
  output logic      [mode_strap_pkg::DATA_W-1:0]    reg_rdata,
  // configuration and gating
  output mode_strap_pkg::config_s                   cfg,
  output mode_strap_pkg::bus_mode_e                 bus_mode,
  output logic      [1:0]                           rate_code,
  output logic                                      rate_undefined,
  output logic                                      adc_low_power,
  output mode_strap_pkg::gate_s                     gates
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    mode_strap_pkg::load_e   load;                   // capture sequence
    logic [1:0]              settle;                 // settle counter
    mode_strap_pkg::config_s cfg;                    // captured straps
    logic [3:0]              scfg;                   // serial configuration
    mode_strap_pkg::gate_s   gates;                  // registered gates
    mode_strap_pkg::bus_mode_e mode;                 // effective mode
    logic [1:0]              rate;                   // effective rate
    logic                    undef;                  // undefined rate
    logic                    conflict;               // 1x on interleaved bus
    logic [mode_strap_pkg::DATA_W-1:0] rdata;        // read data
  } state_s;

  state_s                  cur_q;                    // registered state
  state_s                  nxt_d;                    // next state
  logic [1:0]              rst_pipe_q;               // reset release flops
  logic                    rst_sync_b;               // synchronised reset
  mode_strap_pkg::pins_s   pins;                     // synchronised pins
  mode_strap_pkg::bus_mode_e eff_mode;               // mode now in force
  logic [1:0]              eff_rate;                 // rate now in force
  logic                    half_duplex;              // half duplex active
  logic                    run;                      // configuration valid
  logic [mode_strap_pkg::DATA_W-1:0] status_word;    // status read value

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  // assert at once, release after two edges
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_pipe_q <= 2'h0;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end

  assign rst_sync_b = rst_pipe_q[1];

  // ---------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------
  // all pins are asynchronous to mclk
  pin_sync #(
    .WIDTH ($bits(mode_strap_pkg::pins_s))
  ) u_pin_sync (
    .mclk    (mclk),
    .rst_b   (rst_sync_b),
    .pin_in  ({serial_select_pin,
               serial_output_pin,
               flex_pin_b,
               serial_data_pin,
               serial_clock_pin,
               adc_economy_strap,
               rx_sleep_pin,
               tx_sleep_pin,
               flex_pin_a}),
    .pin_out (pins)
  );

  // ---------------------------------------------------------------
  // effective configuration
  // ---------------------------------------------------------------
  // serial port chooses register fields, else straps
  always_comb begin
    if (cur_q.cfg.serial_enable) begin
      if (cur_q.scfg[mode_strap_pkg::SCFG_FD_BIT]) begin
        eff_mode = mode_strap_pkg::full_duplex_mode;
      end else if (cur_q.scfg[mode_strap_pkg::SCFG_NARROW_BIT]) begin
        eff_mode = mode_strap_pkg::half_duplex_narrow;
      end else begin
        eff_mode = mode_strap_pkg::half_duplex_wide;
      end
      eff_rate = cur_q.scfg[mode_strap_pkg::SCFG_RATE_LSB +: 2];
    end else begin
      eff_mode = cur_q.cfg.mode;
      eff_rate = cur_q.cfg.rate;
    end
  end

  assign half_duplex = (eff_mode != mode_strap_pkg::full_duplex_mode);
  assign run         = cur_q.cfg.valid;

  // ---------------------------------------------------------------
  // status view
  // ---------------------------------------------------------------
  // assembled from captured and live state
  always_comb begin
    status_word = '0;
    status_word[mode_strap_pkg::ST_VALID_BIT]    = cur_q.cfg.valid;
    status_word[mode_strap_pkg::ST_SERIAL_BIT]   = cur_q.cfg.serial_enable;
    status_word[mode_strap_pkg::ST_MODE_LSB +: 2] = cur_q.mode;
    status_word[mode_strap_pkg::ST_RATE_LSB +: 2] = cur_q.rate;
    status_word[mode_strap_pkg::ST_UNDEF_BIT]    = cur_q.undef;
    status_word[mode_strap_pkg::ST_CONFLICT_BIT] = cur_q.conflict;
    status_word[mode_strap_pkg::ST_ECONOMY_BIT]  = cur_q.cfg.adc_economy;
    status_word[mode_strap_pkg::ST_RX_SLEEP_BIT] = pins.rx_sleep;
    status_word[mode_strap_pkg::ST_TX_SLEEP_BIT] = pins.tx_sleep;
    status_word[mode_strap_pkg::ST_DIR_BIT]      = pins.dir_tx;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_d       = cur_q;
    nxt_d.rdata = '0;

    // capture sequence
    case (cur_q.load)
      // let synchronised straps settle after release
      mode_strap_pkg::st_settle: begin
        if (cur_q.settle == mode_strap_pkg::STRAP_SETTLE_CYC - 2'h1) begin
          nxt_d.load = mode_strap_pkg::st_capture;
        end else begin
          nxt_d.settle = cur_q.settle + 2'h1;
        end
      end
      // one-shot capture of select and economy straps, and of mode and rate straps unless the port is selected
      mode_strap_pkg::st_capture: begin
        nxt_d.cfg.valid         = 1'b1;
        nxt_d.cfg.serial_enable = pins.serial_select;
        nxt_d.cfg.adc_economy   = pins.adc_economy_strap;
        if (pins.serial_select) begin
          // port active: mode and rate straps ignored
          nxt_d.cfg.mode = mode_strap_pkg::half_duplex_wide;
          nxt_d.cfg.rate = mode_strap_pkg::RATE_1X;
        end else begin
          if (pins.duplex_strap) begin
            nxt_d.cfg.mode = mode_strap_pkg::full_duplex_mode;
          end else if (pins.width_strap) begin
            nxt_d.cfg.mode = mode_strap_pkg::half_duplex_narrow;
          end else begin
            nxt_d.cfg.mode = mode_strap_pkg::half_duplex_wide;
          end
          nxt_d.cfg.rate = {pins.rate_strap_high,
                            pins.rate_strap_low};
        end
        nxt_d.load = mode_strap_pkg::st_run;
      end
      // configuration frozen until the next reset
      mode_strap_pkg::st_run: begin
        nxt_d.load = mode_strap_pkg::st_run;
      end
      // recover by capturing again
      default: begin
        nxt_d.load   = mode_strap_pkg::st_settle;
        nxt_d.settle = 2'h0;
      end
    endcase

    // serial configuration write, only once port is live
    if (reg_wr && reg_addr == mode_strap_pkg::REG_SERIAL_CFG &&
        cur_q.cfg.serial_enable) begin
      nxt_d.scfg = reg_wdata[3:0];
    end

    // register read, answered next cycle
    if (reg_rd) begin
      case (reg_addr)
        mode_strap_pkg::REG_STATUS: begin
          nxt_d.rdata = status_word;
        end
        mode_strap_pkg::REG_SERIAL_CFG: begin
          nxt_d.rdata = {{(mode_strap_pkg::DATA_W-4){1'b0}}, cur_q.scfg};
        end
        // unmapped reads return zero
        default: begin
          nxt_d.rdata = '0;
        end
      endcase
    end

    // effective mode and rate, registered
    nxt_d.mode  = eff_mode;
    nxt_d.rate  = eff_rate;
    nxt_d.undef = run && (eff_rate == mode_strap_pkg::RATE_UNDEF);
    // 1x on an interleaved bus sets the conflict flag
    nxt_d.conflict = run && (eff_rate == mode_strap_pkg::RATE_1X) &&
                     (eff_mode != mode_strap_pkg::half_duplex_wide);

    // receive side: sleep stops adc, clocks, bias
    nxt_d.gates.adc_clk_en    = run && !pins.rx_sleep;
    nxt_d.gates.rx_bias_en    = !pins.rx_sleep;
    nxt_d.gates.rx_dig_clk_en = run && !pins.rx_sleep &&
                                !(half_duplex && pins.dir_tx);

    // transmit side: sleep stops dac and clocks
    nxt_d.gates.dac_clk_en    = run && !pins.tx_sleep &&
                                !nxt_d.undef;
    nxt_d.gates.tx_bias_en    = !pins.tx_sleep;
    nxt_d.gates.tx_dig_clk_en = run && !pins.tx_sleep && !nxt_d.undef &&
                                !(half_duplex && !pins.dir_tx);

    // pll kept alive through transmit sleep
    nxt_d.gates.pll_en = run && !nxt_d.undef;

    // data bus direction
    if (!run) begin
      // bus stays in input state before capture
      nxt_d.gates.upper_bus_oe = 1'b0;
      nxt_d.gates.lower_bus_oe = 1'b0;
    end else if (!half_duplex) begin
      // full duplex: lower bus carries receive data
      nxt_d.gates.upper_bus_oe = 1'b0;
      nxt_d.gates.lower_bus_oe = !pins.rx_sleep;
    end else if (pins.dir_tx) begin
      // transmit direction: bus is high-impedance input
      nxt_d.gates.upper_bus_oe = 1'b0;
      nxt_d.gates.lower_bus_oe = 1'b0;
    end else begin
      // receive direction: drive out, or three-state in sleep
      nxt_d.gates.lower_bus_oe = !pins.rx_sleep;
      nxt_d.gates.upper_bus_oe = !pins.rx_sleep &&
        (eff_mode == mode_strap_pkg::half_duplex_wide);
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // reset loads constants only
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cur_q.load               <= mode_strap_pkg::st_settle;
      cur_q.settle             <= 2'h0;
      cur_q.cfg.valid          <= 1'b0;
      cur_q.cfg.serial_enable  <= 1'b0;
      cur_q.cfg.mode           <= mode_strap_pkg::half_duplex_wide;
      cur_q.cfg.rate           <= mode_strap_pkg::RATE_1X;
      cur_q.cfg.adc_economy    <= 1'b0;
      cur_q.scfg               <= mode_strap_pkg::SCFG_RESET;
      cur_q.gates              <= '0;
      cur_q.mode               <= mode_strap_pkg::half_duplex_wide;
      cur_q.rate               <= mode_strap_pkg::RATE_1X;
      cur_q.undef              <= 1'b0;
      cur_q.conflict           <= 1'b0;
      cur_q.rdata              <= '0;
    end else begin
      cur_q <= nxt_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata      = cur_q.rdata;               // read data
  assign cfg            = cur_q.cfg;                 // captured straps
  assign bus_mode       = cur_q.mode;                // mode in force
  assign rate_code      = cur_q.rate;                // interpolation and pll
  assign rate_undefined = cur_q.undef;               // code 11 seen
  assign adc_low_power  = cur_q.cfg.adc_economy;
  assign gates          = cur_q.gates;               // clock and bus gates

endmodule

// *** rtl/mode_strap_pkg.sv ***
package mode_strap_pkg;

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;                // register address width
  localparam int unsigned DATA_W = 32;               // register data width
  localparam logic [7:0]  REG_STATUS     = 8'h00;    // read-only configuration view
  localparam logic [7:0]  REG_SERIAL_CFG = 8'h04;    // serial-port configuration

  // status word bit positions
  localparam int unsigned ST_VALID_BIT    = 0;       // straps captured
  localparam int unsigned ST_SERIAL_BIT   = 1;       // serial port enabled
  localparam int unsigned ST_MODE_LSB     = 2;       // bus mode, 2 bits
  localparam int unsigned ST_RATE_LSB     = 4;       // rate code, 2 bits
  localparam int unsigned ST_UNDEF_BIT    = 6;       // rate code undefined
  localparam int unsigned ST_CONFLICT_BIT = 7;       // 1x with interleaved bus
  localparam int unsigned ST_ECONOMY_BIT  = 8;       // adc low-power mode
  localparam int unsigned ST_RX_SLEEP_BIT = 9;       // live receive sleep
  localparam int unsigned ST_TX_SLEEP_BIT = 10;      // live transmit sleep
  localparam int unsigned ST_DIR_BIT      = 11;      // live direction select

  // serial configuration field layout
  localparam int unsigned SCFG_FD_BIT     = 0;       // full duplex
  localparam int unsigned SCFG_NARROW_BIT = 1;       // narrow half duplex
  localparam int unsigned SCFG_RATE_LSB   = 2;       // rate code, 2 bits
  localparam logic [3:0]  SCFG_RESET      = 4'h0;    // reset value

  // ---------------------------------------------------------------
  // rate codes and timing
  // ---------------------------------------------------------------
  localparam logic [1:0] RATE_1X    = 2'h0;          // no interpolation
  localparam logic [1:0] RATE_2X    = 2'h1;          // 2x interpolation and pll
  localparam logic [1:0] RATE_4X    = 2'h2;          // 4x interpolation and pll
  localparam logic [1:0] RATE_UNDEF = 2'h3;          // undefined code
  localparam logic [1:0] STRAP_SETTLE_CYC = 2'h2;    // pin synchroniser depth

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    half_duplex_wide,
    half_duplex_narrow,
    full_duplex_mode
  } bus_mode_e;

  typedef enum logic [1:0] {
    st_settle,
    st_capture,
    st_run
  } load_e;

  // pins as seen after the synchroniser
  typedef struct packed {
    logic serial_select;                             // serial port enable strap
    logic duplex_strap;                              // from serial output pin
    logic width_strap;                               // from flex pin b
    logic rate_strap_high;                           // from serial data pin
    logic rate_strap_low;                            // from serial clock pin
    logic adc_economy_strap;                         // adc power strap
    logic rx_sleep;                                  // live receive sleep
    logic tx_sleep;                                  // live transmit sleep
    logic dir_tx;                                    // live direction select
  } pins_s;

  // captured configuration
  typedef struct packed {
    logic      valid;                                // capture done
    logic      serial_enable;                        // serial port in use
    bus_mode_e mode;                                 // strap bus mode
    logic [1:0] rate;                                // strap rate code
    logic      adc_economy;                          // adc low power
  } config_s;

  // clock gates, bias enables and bus direction
  typedef struct packed {
    logic adc_clk_en;
    logic rx_dig_clk_en;
    logic rx_bias_en;
    logic dac_clk_en;
    logic tx_dig_clk_en;
    logic tx_bias_en;
    logic pll_en;
    logic upper_bus_oe;
    logic lower_bus_oe;
  } gate_s;

endpackage

// *** rtl/pin_sync.sv ***
`timescale 1ns/100ps

// ---------------------------------------------------------------
// two-stage synchroniser for asynchronous pins
// ---------------------------------------------------------------
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] meta_q;                          // first stage, read only below

  // two flops; first stage feeds only the second
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q  <= '0;
      pin_out <= '0;
    end else begin
      meta_q  <= pin_in;
      pin_out <= meta_q;
    end
  end

endmodule

// *** dv/mode_strap_props.sv ***
`timescale 1ns/100ps

// ---------------------------------------------------------------
// port checks for strap capture and clock gating
// ---------------------------------------------------------------
module mode_strap_checker (
  input wire logic                      mclk,
  input wire logic                      rst_b,
  input wire logic                      rx_sleep_pin,
  input wire logic                      tx_sleep_pin,
  input wire logic                      flex_pin_a,
  input wire mode_strap_pkg::config_s   cfg,
  input wire mode_strap_pkg::bus_mode_e bus_mode,
  input wire logic [1:0]                rate_code,
  input wire logic                      rate_undefined,
  input wire logic                      adc_low_power,
  input wire mode_strap_pkg::gate_s     gates
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // live pins as they stood when the outputs were launched, three edges back
  // gates, mode and rate trail the capture by one edge, so wait one valid edge
  sequence s_rx_off;
    cfg.valid && $past(rx_sleep_pin, 3);
  endsequence
  sequence s_tx_off;
    cfg.valid && $past(cfg.valid) && $past(tx_sleep_pin, 3) && !rate_undefined;
  endsequence
  sequence s_half_dir(bit d);
    cfg.valid && $past(cfg.valid) && bus_mode != mode_strap_pkg::full_duplex_mode && $past(flex_pin_a, 3) == d;
  endsequence

  chk_rx_sleep_gates: assert property (s_rx_off |-> !gates.adc_clk_en && !gates.rx_dig_clk_en
    && !gates.rx_bias_en && !gates.lower_bus_oe && !gates.upper_bus_oe) else $error("rx sleep gating wrong");
  chk_rx_awake_on: assert property (cfg.valid && $past(cfg.valid) && !$past(rx_sleep_pin, 3) |->
    gates.adc_clk_en && gates.rx_bias_en) else $error("rx analog off while awake");
  chk_tx_sleep_pll: assert property (s_tx_off |-> !gates.dac_clk_en && !gates.tx_dig_clk_en
    && !gates.tx_bias_en && gates.pll_en) else $error("tx sleep gating wrong");
  chk_tx_bias_kept: assert property (cfg.valid && !$past(tx_sleep_pin, 3) |-> gates.tx_bias_en)
    else $error("tx bias off while awake");
  chk_dir_tx_side: assert property (s_half_dir(1'b1) |-> !gates.rx_dig_clk_en
    && !gates.upper_bus_oe && !gates.lower_bus_oe) else $error("transmit direction gating wrong");
  chk_dir_rx_side: assert property (s_half_dir(1'b0) |-> !gates.tx_dig_clk_en
    && gates.lower_bus_oe == !$past(rx_sleep_pin, 3)) else $error("receive direction gating wrong");
  chk_full_no_dir: assert property (cfg.valid && bus_mode == mode_strap_pkg::full_duplex_mode |->
    gates.rx_dig_clk_en == !$past(rx_sleep_pin, 3) && !gates.upper_bus_oe
    && gates.tx_dig_clk_en == (!$past(tx_sleep_pin, 3) && !rate_undefined)) else $error("full duplex gating wrong");
  chk_cfg_frozen: assert property (cfg.valid && $past(cfg.valid) |-> $stable(cfg))
    else $error("captured configuration moved");
  chk_undef_tx_off: assert property (rate_undefined |-> !gates.dac_clk_en && !gates.tx_dig_clk_en
    && !gates.pll_en) else $error("undefined rate left tx running");
  chk_econ_follows: assert property (cfg.valid |-> adc_low_power == cfg.adc_economy)
    else $error("adc low power differs from capture");
  chk_undef_code: assert property (cfg.valid |-> rate_undefined == (rate_code == 2'h3))
    else $error("undefined flag differs from rate code");
endmodule

bind mode_strap_and_power_gating mode_strap_checker i_chk (.mclk, .rst_b, .rx_sleep_pin, .tx_sleep_pin,
  .flex_pin_a, .cfg, .bus_mode, .rate_code, .rate_undefined, .adc_low_power, .gates);

// *** dv/strap_board.sv ***
`timescale 1ns/100ps

// ---------------------------------------------------------------
// board straps and baseband control pins
// ---------------------------------------------------------------
module strap_board (
  input  wire logic       mclk,
  input  wire logic [5:0] strap_set,   // select, duplex, width, rate hi, rate lo, economy
  input  wire logic [2:0] live_set,    // rx sleep, tx sleep, direction
  input  wire logic       straps_held, // resistors still in charge
  output logic      [5:0] strap_pins,
  output logic      [2:0] live_pins
);
  initial strap_pins = 6'h00;
  initial live_pins = 3'h0;
  // once released the shared lines carry other traffic, so they toggle
  always @(posedge mclk) begin
    strap_pins[5] <= strap_set[5]; // select held for the whole run
    strap_pins[4:0] <= straps_held ? strap_set[4:0] : ~strap_pins[4:0];
    live_pins <= live_set;
  end
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/100ps

module tb_top;
  logic                      mclk = 1'b0;
  logic                      rst_b = 1'b0;
  logic [5:0]                strap_set = 6'h00;
  logic [2:0]                live_set = 3'h0;
  logic                      held = 1'b1;
  logic [5:0]                sp;
  logic [2:0]                lp;
  logic [7:0]                reg_addr = 8'h00;
  logic [31:0]               reg_wdata = 32'h0;
  logic                      reg_wr = 1'b0;
  logic                      reg_rd = 1'b0;
  logic [31:0]               reg_rdata;
  logic [31:0]               rd;
  mode_strap_pkg::config_s   cfg;
  mode_strap_pkg::bus_mode_e bus_mode;
  logic [1:0]                rate_code;
  logic                      rate_undefined;
  logic                      adc_low_power;
  mode_strap_pkg::gate_s     gates;
  int                        bad_count = 0;
  int                        tests_run = 0;
  // select, duplex, width, rate hi, rate lo, economy; full duplex only with 2x or 4x
  logic [5:0]                tbl [6] = '{6'h00, 6'h0B, 6'h14, 6'h1B, 6'h06, 6'h3D};

  always #20 mclk = ~mclk;

  strap_board i_board (.mclk(mclk), .strap_set(strap_set), .live_set(live_set), .straps_held(held),
    .strap_pins(sp), .live_pins(lp));

  mode_strap_and_power_gating i_dut (.mclk(mclk), .rst_b(rst_b), .serial_select_pin(sp[5]),
    .serial_output_pin(sp[4]), .flex_pin_b(sp[3]), .serial_data_pin(sp[2]), .serial_clock_pin(sp[1]),
    .adc_economy_strap(sp[0]), .rx_sleep_pin(lp[2]), .tx_sleep_pin(lp[1]), .flex_pin_a(lp[0]),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cfg(cfg), .bus_mode(bus_mode), .rate_code(rate_code), .rate_undefined(rate_undefined),
    .adc_low_power(adc_low_power), .gates(gates));

  // ---------------------------------------------------------------
  // compare, bus and closing tasks
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one-cycle write strobe
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask

  // reset with the given straps, then let the board release the lines
  task automatic boot(input logic [5:0] s);
    @(posedge mclk);
    strap_set <= s;
    held <= 1'b1;
    rst_b <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    for (int i = 0; i < 20 && cfg.valid !== 1'b1; i++) @(negedge mclk);
    // mode, rate and gates follow the capture one edge later
    @(negedge mclk);
    chk("valid", 32'h1, cfg.valid);
    held <= 1'b0;
  endtask

  // every sleep and direction combination against the expected gates
  task automatic live_sweep(input mode_strap_pkg::bus_mode_e m, input logic [1:0] r);
    logic                  half, wide, und, rx, tx, dir;
    mode_strap_pkg::gate_s g;
    half = m != mode_strap_pkg::full_duplex_mode;
    wide = m == mode_strap_pkg::half_duplex_wide;
    und = r == 2'h3;
    for (int k = 0; k < 8; k++) begin
      {rx, tx, dir} = k[2:0];
      live_set <= k[2:0];
      repeat (5) @(negedge mclk);
      g = '{!rx, !rx && !(half && dir), !rx, !tx && !und, !tx && !(half && !dir) && !und, !tx, !und,
            half && wide && !dir && !rx, (!half || !dir) && !rx};
      chk("gates", g, gates);
      reg_read(8'h00, rd);
      chk("live status", {dir, tx, rx}, rd[11:9]);
    end
    live_set <= 3'h0;
  endtask

  // ---------------------------------------------------------------
  // main sequence: each strap set, register port, live pins
  // ---------------------------------------------------------------
  initial begin
    logic [5:0]                s;
    logic [1:0]                r;
    mode_strap_pkg::bus_mode_e m;
    for (int e = 0; e < 6; e++) begin
      s = tbl[e];
      boot(s);
      m = (s[5] || !s[4]) ? (s[3] && !s[5] ? mode_strap_pkg::half_duplex_narrow : mode_strap_pkg::half_duplex_wide)
          : mode_strap_pkg::full_duplex_mode;
      r = s[5] ? 2'h0 : s[2:1];
      chk("mode", m, bus_mode);
      chk("rate", r, rate_code);
      chk("undefined", r == 2'h3, rate_undefined);
      chk("economy", s[0], adc_low_power);
      chk("serial", s[5], cfg.serial_enable);
      repeat (8) @(negedge mclk);
      chk("held config", {1'b1, s[5], m, r, s[0]}, cfg);
      reg_read(8'h00, rd);
      chk("status", {23'h0, s[0], r == 2'h0 && m != 2'h0, r == 2'h3, r, m, s[5], 1'b1}, rd);
      reg_write(8'h04, 32'hFFFF_FFFA);
      reg_read(8'h04, rd);
      chk("serial cfg", s[5] ? 32'hA : 32'h0, rd);
      reg_write(8'h00, 32'h0);
      reg_write(8'h08, 32'h5);
      reg_read(8'h08, rd);
      chk("unmapped", 32'h0, rd);
      reg_read(8'h00, rd);
      chk("read only", 32'h1, rd[0]);
      if (s[5]) begin
        m = mode_strap_pkg::half_duplex_narrow;
        r = 2'h2;
        chk("serial mode", {m, r}, {bus_mode, rate_code});
        // full duplex at 1x through the port: flagged as a conflict
        reg_write(8'h04, 32'h1);
        reg_read(8'h00, rd);
        chk("serial full", 32'h8B, rd[7:0]);
        m = mode_strap_pkg::full_duplex_mode;
        r = 2'h0;
      end
      live_sweep(m, r);
    end
    close_out();
  end

  // watchdog: the run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge mclk);
    bad_count++;
    close_out();
  end
endmodule
